// file: core/csme_consts.svh
// Constants for the core state, mode and data-lane control block
// Operation
// - In the wide state instructions are 32 bits long and word aligned.
// - In the compact state instructions are 16 bits long and halfword aligned.
// - In the compact state program counter bit 1 picks the halfword of the fetched word.
// - Changing instruction state leaves the mode and all register values unchanged.
// - State changes only on branch-exchange, branch-link-exchange or a load to the program counter; the code also changes it on exception entry and return.
// - Any exception forces the wide state, kept through handling until the return.
// - Returning from a handler entered from the compact state restores the compact state.
// - Memory is bytes numbered from zero, four consecutive bytes forming each word.
// - Big-endian puts byte 0 on data bits 31 to 24.
// - Little-endian puts byte 0 on data bits 7 to 0.
// - Word, halfword and byte accesses exist, aligned to four, two and one bytes.
// - Seven modes exist: user, fast interrupt, interrupt, supervisor, abort, system, undefined.
// - Data abort and prefetch abort enter abort mode.
// - An undefined instruction exception enters undefined mode.
// - Every mode but user is privileged, and exceptions always run privileged.
// - The program counter has bits 1:0 zero in wide state and bit 0 zero in compact state.
`ifndef CSME_CONSTS_SVH
`define CSME_CONSTS_SVH

`define CSME_PC_RESET     32'h0000_0000
`define CSME_WORD_ALIGN   2'h3
`define CSME_HALF_ALIGN   2'h1
`define CSME_HALF_SEL_BIT 1
`define CSME_LANE0_BE     3
`define CSME_LANE0_LE     0

`endif

// file: core/csme_core_ctrl.sv
// Top: instruction state, operating mode, program counter and data lanes
`timescale 1ns/1ps
`default_nettype none
`include "csme_consts.svh"
module csme_core_ctrl
  import csme_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Static configuration pin
  input  wire logic        big_endian_i,
  // Execute events, one-cycle pulses
  input  wire logic        step_i,
  input  wire logic        branch_exchange_i,
  input  wire logic        branch_link_exchange_i,
  input  wire logic        load_pc_i,
  input  wire logic [31:0] target_i,
  input  wire csme_exc_t   exc_i,
  input  wire logic [31:0] vector_i,
  input  wire logic        exc_return_i,
  input  wire logic [31:0] return_addr_i,
  input  wire logic        mode_wr_i,
  input  wire csme_mode_t  mode_wdata_i,
  // Fetch side
  input  wire logic [31:0] fetch_word_i,
  output logic [31:0]      pc_o,
  output logic             compact_o,
  output logic [31:0]      instr_o,
  // Mode
  output csme_mode_t       mode_o,
  output logic             priv_o,
  // Data access
  input  wire logic        dreq_i,
  input  wire logic [31:0] daddr_i,
  input  wire csme_size_t  dsize_i,
  input  wire logic [31:0] dwdata_i,
  input  wire logic [31:0] bus_rdata_i,
  output logic [31:0]      bus_addr_o,
  output logic [31:0]      bus_wdata_o,
  output logic [3:0]       bus_lane_o,
  output logic             bus_req_o,
  output logic [31:0]      drdata_o,
  output logic             misalign_o,
  output logic             big_end_o
);
  // Internal state
  logic        compact_reg;
  logic        saved_compact_reg;
  logic        in_handler_reg;
  logic [31:0] pc_reg;
  csme_mode_t  mode_reg;
  csme_mode_t  saved_mode_reg;
  logic        be_sync1_reg;
  logic        be_sync2_reg;
  logic        be_reg;
  logic        rst_done_reg;
  csme_mode_t  exc_mode;
  logic        priv_now;
  logic [31:0] st_wdata;
  logic [31:0] st_rdata;
  logic [3:0]  st_lane;
  logic        st_mis;
  logic        exch;
  logic        exc_take;

  // Program counter alignment for a given state
  function automatic logic [31:0] align_pc(input logic [31:0] a, input logic cmp);
    align_pc = cmp ? (a & ~32'h0000_0001) : (a & ~32'h0000_0003);
  endfunction

  assign exch     = branch_exchange_i | branch_link_exchange_i | load_pc_i;
  assign exc_take = (exc_i != CSME_EXC_NONE);

  csme_mode_map u_mode_map (
    .exc_i      (exc_i),
    .mode_i     (mode_reg),
    .exc_mode_o (exc_mode),
    .priv_o     (priv_now)
  );

  csme_lane_steer u_lane (
    .addr_lo_i   (daddr_i[1:0]),
    .size_i      (dsize_i),
    .big_end_i   (be_reg),
    .wdata_i     (dwdata_i),
    .bus_rdata_i (bus_rdata_i),
    .bus_wdata_o (st_wdata),
    .lane_en_o   (st_lane),
    .rdata_o     (st_rdata),
    .misalign_o  (st_mis)
  );

  // Endian pin synchroniser; kept out of reset so it tracks the strap while the core is held
  always_ff @(posedge ref_clk_i) begin
    be_sync1_reg <= big_endian_i;
    be_sync2_reg <= be_sync1_reg;
  end

  // Byte order latched only in the first cycle after reset release, then frozen
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      be_reg       <= 1'b0;
      rst_done_reg <= 1'b0;
    end else if (!rst_done_reg) begin
      be_reg       <= be_sync2_reg;
      rst_done_reg <= 1'b1;
    end
  end

  // Instruction state; exception outranks return, which outranks exchange
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      compact_reg       <= 1'b0;
      saved_compact_reg <= 1'b0;
      in_handler_reg    <= 1'b0;
    end else if (exc_take) begin
      saved_compact_reg <= compact_reg;
      compact_reg       <= 1'b0;
      in_handler_reg    <= 1'b1;
    end else if (exc_return_i && in_handler_reg) begin
      compact_reg    <= saved_compact_reg;
      in_handler_reg <= 1'b0;
    end else if (exch && !in_handler_reg) begin
      compact_reg <= target_i[0];
    end
  end

  // Mode: untouched by state change, set by exceptions or privileged writes
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg       <= CSME_MODE_SVC;
      saved_mode_reg <= CSME_MODE_SVC;
    end else if (exc_take) begin
      saved_mode_reg <= mode_reg;
      mode_reg       <= exc_mode;
    end else if (exc_return_i && in_handler_reg) begin
      mode_reg <= saved_mode_reg;
    end else if (mode_wr_i && priv_now) begin
      mode_reg <= mode_wdata_i;
    end
  end

  // Program counter; step size follows the instruction length
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_reg <= `CSME_PC_RESET;
    end else if (exc_take) begin
      pc_reg <= align_pc(vector_i, 1'b0);
    end else if (exc_return_i && in_handler_reg) begin
      pc_reg <= align_pc(return_addr_i, saved_compact_reg);
    end else if (exch && !in_handler_reg) begin
      pc_reg <= align_pc(target_i, target_i[0]);
    end else if (exch) begin
      pc_reg <= align_pc(target_i, 1'b0);
    end else if (step_i) begin
      pc_reg <= compact_reg ? pc_reg + 32'h0000_0002 : pc_reg + 32'h0000_0004;
    end
  end

  // Fetch outputs; halfword pick by pc bit 1 and byte order
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_o      <= `CSME_PC_RESET;
      compact_o <= 1'b0;
      instr_o   <= 32'h0000_0000;
      mode_o    <= CSME_MODE_SVC;
      priv_o    <= 1'b1;
    end else begin
      pc_o      <= pc_reg;
      compact_o <= compact_reg;
      mode_o    <= mode_reg;
      priv_o    <= priv_now;
      if (!compact_reg) begin
        instr_o <= fetch_word_i;
      end else if (pc_reg[`CSME_HALF_SEL_BIT] ^ be_reg) begin
        instr_o <= {16'h0000, fetch_word_i[31:16]};
      end else begin
        instr_o <= {16'h0000, fetch_word_i[15:0]};
      end
    end
  end

  // Data access outputs, registered; misaligned requests are not issued
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_addr_o  <= 32'h0000_0000;
      bus_wdata_o <= 32'h0000_0000;
      bus_lane_o  <= 4'h0;
      bus_req_o   <= 1'b0;
      drdata_o    <= 32'h0000_0000;
      misalign_o  <= 1'b0;
      big_end_o   <= 1'b0;
    end else begin
      bus_addr_o  <= {daddr_i[31:2], 2'b00};
      bus_wdata_o <= st_wdata;
      bus_lane_o  <= (dreq_i && !st_mis) ? st_lane : 4'h0; // no strobes on refusal
      bus_req_o   <= dreq_i && !st_mis;
      misalign_o  <= dreq_i && st_mis;
      drdata_o    <= st_rdata;
      big_end_o   <= be_reg;
    end
  end
endmodule // csme_core_ctrl
`default_nettype wire

// file: core/csme_lane_steer.sv
// Data bus byte-lane steering and alignment check
`timescale 1ns/1ps
`default_nettype none
`include "csme_consts.svh"
module csme_lane_steer
  import csme_pkg::*;
(
  // Access
  input  wire logic [1:0]  addr_lo_i,
  input  wire csme_size_t  size_i,
  input  wire logic        big_end_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [31:0] bus_rdata_i,
  // Results
  output logic [31:0]      bus_wdata_o,
  output logic [3:0]       lane_en_o,
  output logic [31:0]      rdata_o,
  output logic             misalign_o
);
  // Physical lane of a byte address within the word
  function automatic logic [1:0] lane_of(input logic [1:0] a, input logic be);
    lane_of = be ? (2'h3 - a) : a;
  endfunction

  logic [1:0] l0;
  logic [1:0] l1;
  assign l0 = lane_of(addr_lo_i, big_end_i);
  assign l1 = lane_of(addr_lo_i | 2'h1, big_end_i);

  // Alignment and lanes; misaligned accesses still present a lane pattern
  always_comb begin
    misalign_o  = 1'b0;
    lane_en_o   = 4'h0;
    bus_wdata_o = 32'h0000_0000;
    rdata_o     = 32'h0000_0000;
    case (size_i)
      CSME_SIZE_WORD: begin
        misalign_o  = |(addr_lo_i & `CSME_WORD_ALIGN);
        lane_en_o   = 4'hf;
        bus_wdata_o = wdata_i;
        rdata_o     = bus_rdata_i;
      end
      CSME_SIZE_HALF: begin
        misalign_o = addr_lo_i[0];
        lane_en_o[l0] = 1'b1;
        lane_en_o[l1] = 1'b1;
        // Lower byte address holds the halfword's low byte in LE, high byte in BE
        bus_wdata_o[l0*8 +: 8] = big_end_i ? wdata_i[15:8] : wdata_i[7:0];
        bus_wdata_o[l1*8 +: 8] = big_end_i ? wdata_i[7:0] : wdata_i[15:8];
        rdata_o[15:8] = big_end_i ? bus_rdata_i[l0*8 +: 8] : bus_rdata_i[l1*8 +: 8];
        rdata_o[7:0]  = big_end_i ? bus_rdata_i[l1*8 +: 8] : bus_rdata_i[l0*8 +: 8];
      end
      default: begin
        lane_en_o[l0] = 1'b1;
        bus_wdata_o[l0*8 +: 8] = wdata_i[7:0];
        rdata_o[7:0] = bus_rdata_i[l0*8 +: 8];
      end
    endcase
  end
endmodule // csme_lane_steer
`default_nettype wire

// file: core/csme_mode_map.sv
// Exception to mode mapping and privilege decode
`timescale 1ns/1ps
`default_nettype none
module csme_mode_map
  import csme_pkg::*;
(
  // Inputs
  input  wire csme_exc_t  exc_i,
  input  wire csme_mode_t mode_i,
  // Results
  output var  csme_mode_t exc_mode_o,
  output logic            priv_o
);
  // Every exception lands in a privileged mode
  always_comb begin
    case (exc_i)
      CSME_EXC_FIQ:    exc_mode_o = CSME_MODE_FIQ;
      CSME_EXC_IRQ:    exc_mode_o = CSME_MODE_IRQ;
      CSME_EXC_DABORT: exc_mode_o = CSME_MODE_ABORT;
      CSME_EXC_PABORT: exc_mode_o = CSME_MODE_ABORT;
      CSME_EXC_UNDEF:  exc_mode_o = CSME_MODE_UNDEF;
      default:         exc_mode_o = CSME_MODE_SVC;
    endcase
  end
  assign priv_o = (mode_i != CSME_MODE_USER);
endmodule // csme_mode_map
`default_nettype wire

// file: core/csme_pkg.sv
// Types for the core state, mode and data-lane control block
package csme_pkg;
  typedef enum logic [2:0] {
    CSME_MODE_USER, CSME_MODE_FIQ, CSME_MODE_IRQ, CSME_MODE_SVC,
    CSME_MODE_ABORT, CSME_MODE_SYSTEM, CSME_MODE_UNDEF
  } csme_mode_t;
  typedef enum logic [1:0] {CSME_SIZE_BYTE, CSME_SIZE_HALF, CSME_SIZE_WORD} csme_size_t;
  typedef enum logic [2:0] {
    CSME_EXC_NONE, CSME_EXC_FIQ, CSME_EXC_IRQ, CSME_EXC_SWI,
    CSME_EXC_DABORT, CSME_EXC_PABORT, CSME_EXC_UNDEF, CSME_EXC_RESET
  } csme_exc_t;
endpackage

// file: verification/csme_core_ctrl_assertions.sv
// Checker for the core state, mode and data-lane control block
`timescale 1ns/1ps
`default_nettype none
module csme_core_ctrl_chk
  import csme_pkg::*;
(
  // Clock, reset and causes
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        dreq_i,
  input wire logic [31:0] daddr_i,
  input wire csme_size_t  dsize_i,
  input wire csme_exc_t   exc_i,
  input wire logic        branch_exchange_i,
  input wire logic        branch_link_exchange_i,
  input wire logic        load_pc_i,
  input wire logic        exc_return_i,
  // Outputs watched
  input wire logic [31:0] pc_o,
  input wire logic        compact_o,
  input wire csme_mode_t  mode_o,
  input wire logic        priv_o,
  input wire logic [3:0]  bus_lane_o,
  input wire logic        bus_req_o,
  input wire logic        misalign_o,
  input wire logic        big_end_o
);
  logic       ev_any;
  logic [1:0] a_lo;
  // Only these events may move the instruction state
  assign ev_any = branch_exchange_i | branch_link_exchange_i | load_pc_i | exc_return_i
                  | (exc_i != CSME_EXC_NONE);
  assign a_lo   = daddr_i[1:0];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_PRIV_DECODE: assert property (priv_o == (mode_o != CSME_MODE_USER))
    else $error("privilege flag disagrees with mode");
  AST_PC_ALIGN: assert property ((pc_o[1:0] & {~compact_o, 1'b1}) == 2'h0)
    else $error("program counter misaligned for state");
  AST_EXC_WIDE: assert property (exc_i != CSME_EXC_NONE |-> ##2 !compact_o)
    else $error("exception did not force wide state");
  AST_ABORT_MODE: assert property ((exc_i == CSME_EXC_DABORT || exc_i == CSME_EXC_PABORT)
    |-> ##2 mode_o == CSME_MODE_ABORT) else $error("abort did not enter abort mode");
  AST_UNDEF_MODE: assert property (exc_i == CSME_EXC_UNDEF |-> ##2 mode_o == CSME_MODE_UNDEF)
    else $error("undefined instruction did not enter undefined mode");
  AST_STATE_CAUSE: assert property ($changed(compact_o) |-> $past(ev_any, 2))
    else $error("instruction state changed without cause");
  AST_WORD_LANES: assert property (dreq_i && dsize_i == CSME_SIZE_WORD && a_lo == 2'h0
    |=> bus_req_o && bus_lane_o == 4'hf) else $error("word access lanes wrong");
  AST_MISALIGN: assert property (dreq_i && (dsize_i == CSME_SIZE_WORD && a_lo != 2'h0
    || dsize_i == CSME_SIZE_HALF && a_lo[0]) |=> misalign_o && !bus_req_o && bus_lane_o == 4'h0)
    else $error("misaligned access not refused");
  AST_BYTE_LANE: assert property (dreq_i && dsize_i == CSME_SIZE_BYTE |=> bus_lane_o ==
    (big_end_o ? 4'h8 >> $past(a_lo) : 4'h1 << $past(a_lo))) else $error("byte lane wrong");
  AST_IDLE_LANES: assert property (!dreq_i |=> !bus_req_o && bus_lane_o == 4'h0)
    else $error("bus active without request");
  // Main scenarios reached
  cover property (bus_req_o);
  cover property (misalign_o);
  cover property (exc_i == CSME_EXC_DABORT ##2 mode_o == CSME_MODE_ABORT);
endmodule // csme_core_ctrl_chk
bind csme_core_ctrl csme_core_ctrl_chk csme_core_ctrl_chk_i (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .dreq_i(dreq_i), .daddr_i(daddr_i), .dsize_i(dsize_i), .exc_i(exc_i),
  .branch_exchange_i(branch_exchange_i), .branch_link_exchange_i(branch_link_exchange_i),
  .load_pc_i(load_pc_i), .exc_return_i(exc_return_i), .pc_o(pc_o), .compact_o(compact_o),
  .mode_o(mode_o), .priv_o(priv_o), .bus_lane_o(bus_lane_o), .bus_req_o(bus_req_o),
  .misalign_o(misalign_o), .big_end_o(big_end_o));
`default_nettype wire

// file: verification/csme_core_ctrl_tb.sv
// Self-checking bench for the core state, mode and data-lane control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module csme_core_ctrl_tb;
  import csme_pkg::*;
  logic ref_clk_i = 0, rst_n_i = 0, big_endian_i = 0, step_i = 0, branch_exchange_i = 0;
  logic branch_link_exchange_i = 0, load_pc_i = 0, exc_return_i = 0, mode_wr_i = 0;
  logic dreq_i = 0, be = 0, compact_o, priv_o, bus_req_o, misalign_o, big_end_o;
  logic [31:0] target_i = 0, vector_i = 0, return_addr_i = 0, fetch_word_i = 0, daddr_i = 0;
  logic [31:0] dwdata_i = 0, bus_rdata_i, pc_o, instr_o, bus_addr_o, bus_wdata_o, drdata_o, t;
  logic [3:0] bus_lane_o;
  csme_exc_t exc_i = CSME_EXC_NONE;
  csme_mode_t mode_wdata_i = CSME_MODE_USER, mode_o;
  csme_size_t dsize_i = CSME_SIZE_BYTE;
  csme_mode_t mp[7] = '{CSME_MODE_FIQ, CSME_MODE_IRQ, CSME_MODE_SVC, CSME_MODE_ABORT,
                        CSME_MODE_ABORT, CSME_MODE_UNDEF, CSME_MODE_SVC};
  logic [100:0] q[$], note;
  int n_errors = 0, checks_done = 0, seed = 32'hc7d7;
  csme_core_ctrl csme_core_ctrl_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .big_endian_i(big_endian_i), .step_i(step_i), .branch_exchange_i(branch_exchange_i),
    .branch_link_exchange_i(branch_link_exchange_i), .load_pc_i(load_pc_i),
    .target_i(target_i), .exc_i(exc_i), .vector_i(vector_i), .exc_return_i(exc_return_i),
    .return_addr_i(return_addr_i), .mode_wr_i(mode_wr_i), .mode_wdata_i(mode_wdata_i),
    .fetch_word_i(fetch_word_i), .pc_o(pc_o), .compact_o(compact_o), .instr_o(instr_o),
    .mode_o(mode_o), .priv_o(priv_o), .dreq_i(dreq_i), .daddr_i(daddr_i), .dsize_i(dsize_i),
    .dwdata_i(dwdata_i), .bus_rdata_i(bus_rdata_i), .bus_addr_o(bus_addr_o),
    .bus_wdata_o(bus_wdata_o), .bus_lane_o(bus_lane_o), .bus_req_o(bus_req_o),
    .drdata_o(drdata_o), .misalign_o(misalign_o), .big_end_o(big_end_o));
  csme_mem_model csme_mem_model_i (.ref_clk_i(ref_clk_i), .dreq_i(dreq_i),
    .daddr_i(daddr_i), .rdata_o(bus_rdata_i));
  // 250 MHz clock
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Reset with the byte-order strap held steady beforehand
  task automatic rst(input logic b);
    rst_n_i = 0;
    big_endian_i = b;
    be = b;
    repeat (3) @(posedge ref_clk_i);
    #1 rst_n_i = 1;
    repeat (2) @(posedge ref_clk_i);
    #1 `CHK(big_end_o, b)
  endtask
  // One event pulse, then wait out the two-cycle state latency
  task automatic ev(input int k, input logic [31:0] v, input csme_exc_t e = CSME_EXC_NONE);
    target_i = v;
    vector_i = v;
    return_addr_i = v;
    mode_wdata_i = csme_mode_t'(v[2:0]);
    case (k)
      0: step_i = 1;
      1: branch_exchange_i = 1;
      2: branch_link_exchange_i = 1;
      3: load_pc_i = 1;
      4: exc_i = e;
      5: exc_return_i = 1;
      default: mode_wr_i = 1;
    endcase
    @(posedge ref_clk_i);
    #1 {step_i, branch_exchange_i, branch_link_exchange_i, load_pc_i} = 4'h0;
    {exc_return_i, mode_wr_i} = 2'h0;
    exc_i = CSME_EXC_NONE;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic st(input logic [31:0] p, input logic c, input csme_mode_t m);
    `CHK(pc_o, p)
    `CHK(compact_o, c)
    `CHK(mode_o, m)
    `CHK(priv_o, m != CSME_MODE_USER)
  endtask
  // Data access: note the expected lanes and data, left asserted for back-to-back use
  task automatic acc(input logic [31:0] a, input csme_size_t s, input logic [31:0] w);
    int n, lo;
    logic [63:0] m;
    n = (s == CSME_SIZE_WORD) ? 4 : (s == CSME_SIZE_HALF) ? 2 : 1;
    lo = be ? 4 - n - int'(a[1:0]) : int'(a[1:0]);
    m = (64'h1 << 8 * n) - 1;
    if ((n == 4 && a[1:0] != 2'h0) || (n == 2 && a[0]))
      q.push_back({1'b1, 68'h0, a[31:2], 2'h0});
    else q.push_back({1'b0, 4'((1 << n) - 1) << lo, 32'(({32'h0, w} & m) << 8 * lo),
                      32'((({a[31:2], 2'h0} ^ 32'h5a3c_96e1) >> 8 * lo) & m), a[31:2], 2'h0});
    {dreq_i, daddr_i, dsize_i, dwdata_i} = {1'b1, a, s, w};
    @(posedge ref_clk_i);
    #1;
  endtask
  // Result watcher: each request or refusal takes the oldest note
  always @(negedge ref_clk_i) begin
    if (rst_n_i && (bus_req_o === 1'b1 || misalign_o === 1'b1)) begin
      note = q.size() ? q.pop_front() : 101'h0;
      `CHK({misalign_o, bus_lane_o, bus_wdata_o & {{8{bus_lane_o[3]}}, {8{bus_lane_o[2]}},
        {8{bus_lane_o[1]}}, {8{bus_lane_o[0]}}}, misalign_o ? 32'h0 : drdata_o, bus_addr_o},
        note)
    end
  end
  // Watchdog
  initial begin
    #200000 n_errors++;
    print_verdict();
  end
  initial begin
    rst(0);
    st(0, 0, CSME_MODE_SVC);
    fetch_word_i = 32'hbeef_cafe;
    ev(0, 0);
    st(4, 0, CSME_MODE_SVC);
    `CHK(instr_o, 32'hbeef_cafe)
    ev(1, 32'h101);
    st(32'h100, 1, CSME_MODE_SVC);
    `CHK(instr_o[15:0], 16'hcafe)
    ev(0, 0);
    st(32'h102, 1, CSME_MODE_SVC);
    `CHK(instr_o[15:0], 16'hbeef)
    ev(4, 32'h18, CSME_EXC_IRQ);
    ev(1, 32'h41);
    st(32'h40, 0, CSME_MODE_IRQ);
    ev(5, 32'h104);
    st(32'h104, 1, CSME_MODE_SVC);
    ev(6, 32'h0);
    ev(6, 32'h3);
    st(32'h104, 1, CSME_MODE_USER);
    for (int i = 0; i < 7; i++) begin
      ev(4, 32'h1c, csme_exc_t'(i + 1));
      st(32'h1c, 0, mp[i]);
      ev(5, 32'h104);
      st(32'h104, 1, CSME_MODE_USER);
    end
    for (int i = 0; i < 6; i++) begin
      t = $random(seed);
      ev(1 + i % 3, t);
      st(t & (t[0] ? ~32'h1 : ~32'h3), t[0], CSME_MODE_USER);
    end
    for (int b = 0; b < 2; b++) begin
      if (b) begin
        rst(1);
        ev(1, 32'h101);
        `CHK(instr_o[15:0], 16'hbeef)
      end
      for (int a = 0; a < 4; a++)
        for (int s = 0; s < 3; s++) acc(32'h100 + a, csme_size_t'(s), $random(seed));
      dreq_i = 0;
      repeat (3) @(posedge ref_clk_i);
      #1 `CHK(q.size(), 0)
    end
    print_verdict();
  end
endmodule // csme_core_ctrl_tb
`default_nettype wire

// file: verification/csme_mem_model.sv
// Memory model answering data reads on the core's bus
`timescale 1ns/1ps
`default_nettype none
module csme_mem_model (
  // Clock and access
  input  wire logic        ref_clk_i,
  input  wire logic        dreq_i,
  input  wire logic [31:0] daddr_i,
  // Read data
  output logic [31:0]      rdata_o
);
  logic [31:0] last_reg = 32'h0000_0000;
  // Word pattern per word address; unselected bus inverts the value driven the cycle before, so it toggles
  assign rdata_o = dreq_i ? ({daddr_i[31:2], 2'h0} ^ 32'h5a3c_96e1) : ~last_reg;
  // Remember what was last driven
  always @(posedge ref_clk_i) begin
    last_reg <= rdata_o;
  end
endmodule // csme_mem_model
`default_nettype wire
